/* File: verilog/rpd_ctrl.sv */
// reset and power-down controller top
// assumes: cpu decodes opcodes and pulses op_valid with op_code; pins are asynchronous
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`include "rpd_map.svh"
`default_nettype none
module rpd_ctrl (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic external_reset_pin_low,
  input wire logic low_voltage_reset,
  input wire logic opt_use_low_volt,
  input wire logic [15:0] opt_reset_vec,
  input wire logic opt_vec_sel,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  input wire logic [7:0] filtered_ext_irqs,
  input wire logic irq_pending_enabled,
  output logic sys_reset,
  output logic [15:0] pc_load_value,
  output logic pc_load,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_run,
  output logic irq_global_en_clr,
  output logic ports_to_input,
  output logic hold_port_dir,
  output logic wake_irq,
  output logic [1:0] clk_div_sel
);
  logic pin_s1_r;
  logic pin_s2_r;
  logic lv_s1_r;
  logic lv_s2_r;
  logic irq_s1_r;
  logic irq_s2_r;
  logic [7:0] ext_s1_r;
  logic [7:0] ext_s2_r;
  logic [7:0] bt_ctrl_r;
  logic [7:0] clk_ctrl_r;
  logic [7:0] stop_key_r;
  logic [7:0] rdata_r;
  logic [15:0] pcv_r;
  logic pcl_r;
  logic wake_r;
  logic wdt_rst_r;
  logic any_rst;
  logic stop_ok;
  logic ext_wake;
  rpd_pkg::rpd_state_t state_r;
  rpd_pkg::rpd_state_t state_nxt;
  rpd_bt_if bt();

  rpd_basic_timer u_bt (
    .core_clk(core_clk),
    .rstn(rstn),
    .bt(bt)
  );

  // two-flop synchronisers for pins and pending flag
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      lv_s1_r <= 1'b0;
      lv_s2_r <= 1'b0;
      irq_s1_r <= 1'b0;
      irq_s2_r <= 1'b0;
      ext_s1_r <= 8'h00;
      ext_s2_r <= 8'h00;
    end else begin
      pin_s1_r <= external_reset_pin_low;
      pin_s2_r <= pin_s1_r;
      lv_s1_r <= low_voltage_reset;
      lv_s2_r <= lv_s1_r;
      irq_s1_r <= irq_pending_enabled;
      irq_s2_r <= irq_s1_r;
      ext_s1_r <= filtered_ext_irqs;
      ext_s2_r <= ext_s1_r;
    end
  end

  // reset merge; power-on is rstn, option picks supply monitor or pin
  always_comb begin
    any_rst = opt_use_low_volt ? lv_s2_r : !pin_s2_r;
    any_rst = any_rst || wdt_rst_r;
  end

  // watchdog overflow latched one cycle into a reset pulse
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wdt_rst_r <= 1'b0;
    end else begin
      wdt_rst_r <= bt.overflow;
    end
  end

  // control registers; any reset restores defaults
  always_ff @(posedge core_clk) begin
    if (!rstn || any_rst) begin
      bt_ctrl_r <= `RPD_BT_CTRL_RST;
      clk_ctrl_r <= `RPD_CLK_CTRL_RST;
      stop_key_r <= 8'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        `RPD_ADDR_BT_CTRL: bt_ctrl_r <= reg_wdata;
        `RPD_ADDR_CLK_CTRL: clk_ctrl_r <= {reg_wdata[7], 2'b00, reg_wdata[4:3], 3'b000};
        `RPD_ADDR_STOP_KEY: stop_key_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read port, data valid the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `RPD_ADDR_BT_CTRL: rdata_r <= bt_ctrl_r;
        `RPD_ADDR_CLK_CTRL: rdata_r <= clk_ctrl_r;
        `RPD_ADDR_STOP_KEY: rdata_r <= stop_key_r;
        `RPD_ADDR_BT_COUNT: rdata_r <= bt.count;
        `RPD_ADDR_STATUS: rdata_r <= {5'h00, 3'(state_r)};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end
  assign reg_rdata = rdata_r;

  // stop needs the exact key; only reset or filtered irqs with wake enable exit stop
  assign stop_ok = (stop_key_r == `RPD_STOP_KEY);
  assign ext_wake = clk_ctrl_r[`RPD_CLK_CTRL_WAKE_BIT] && (|ext_s2_r);

  // power state sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rpd_pkg::RPD_RESET: state_nxt = rpd_pkg::RPD_STAB;
      rpd_pkg::RPD_STAB: if (bt.stab_done) begin
        state_nxt = rpd_pkg::RPD_RUN;
      end
      rpd_pkg::RPD_RUN: if (op_valid && op_code == `RPD_OP_STOP && stop_ok) begin
        state_nxt = rpd_pkg::RPD_STOP;
      end else if (op_valid && op_code == `RPD_OP_IDLE) begin
        state_nxt = rpd_pkg::RPD_IDLE;
      end
      rpd_pkg::RPD_STOP: if (ext_wake) begin
        state_nxt = rpd_pkg::RPD_STAB;
      end
      rpd_pkg::RPD_IDLE: if (irq_s2_r) begin
        state_nxt = rpd_pkg::RPD_RUN;
      end
      default: state_nxt = rpd_pkg::RPD_RESET;
    endcase
  end

  // reset overrides every state, including stop and idle
  always_ff @(posedge core_clk) begin
    if (!rstn || any_rst) begin
      state_r <= rpd_pkg::RPD_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // vector load and wake-irq flag toward the cpu
  always_ff @(posedge core_clk) begin
    if (!rstn || any_rst) begin
      pcv_r <= `RPD_RESET_VEC;
      pcl_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      pcl_r <= (state_r == rpd_pkg::RPD_RESET);
      pcv_r <= opt_vec_sel ? opt_reset_vec : `RPD_RESET_VEC;
      if (state_r == rpd_pkg::RPD_STOP && ext_wake) begin
        wake_r <= 1'b1;
      end else if (state_r == rpd_pkg::RPD_RUN) begin
        wake_r <= 1'b0;
      end
    end
  end

  // timer link: restart on entry to stabilization; ctrl from before stop
  assign bt.clear = (state_r != rpd_pkg::RPD_STAB) && (state_nxt == rpd_pkg::RPD_STAB);
  assign bt.wdt_en = (bt_ctrl_r[7:4] != `RPD_WDT_OFF_NIB) && (state_r == rpd_pkg::RPD_RUN);
  assign bt.ctrl = bt_ctrl_r;

  // outputs
  assign sys_reset = (state_r == rpd_pkg::RPD_RESET);
  assign pc_load_value = pcv_r;
  assign pc_load = pcl_r;
  assign cpu_clk_en = (state_r == rpd_pkg::RPD_RUN);
  assign periph_clk_en = (state_r != rpd_pkg::RPD_STOP);
  assign osc_run = (state_r != rpd_pkg::RPD_STOP);
  assign irq_global_en_clr = sys_reset;
  assign ports_to_input = sys_reset;
  assign hold_port_dir = (state_r == rpd_pkg::RPD_IDLE);
  assign wake_irq = wake_r;
  assign clk_div_sel = clk_ctrl_r[4:3];
endmodule // rpd_ctrl
`default_nettype wire

/* File: verilog/rpd_map.svh */
// reset and power-down controller: offsets, field positions, reset values, timing counts
// assumes: included by the design modules by bare name
//
// Contract
// - option bit picks low-voltage or pin reset
// - four reset sources are combined
// - external reset pin synchronised to clock
// - any reset restores control register defaults
// - watchdog overflow without refresh resets device
// - low-voltage reset held while supply low
// - 1010B upper nibble disables watchdog reset
// - reset masks irqs, arms watchdog, ports input
// - program counter loaded with reset vector
// - after stabilization fetch vector and run
// - stop opcode halts oscillator, keeps registers
// - stop left only by reset or irq
// - reset exit restores defaults, divide 00B
// - only filtered external irqs wake stop
// - irq wake keeps registers, uses old timer
// - waking irq serviced then resume after stop
// - idle opcode gates cpu clock only
// - port directions held during idle
// - reset ends idle; masked means reset only
// - any enabled irq ends idle, divide kept
// - stop usable only with key 10100101B
// - wake enable bit 7 set after reset
`ifndef RPD_MAP_SVH
`define RPD_MAP_SVH
`define RPD_ADDR_BT_CTRL 8'hD3
`define RPD_ADDR_CLK_CTRL 8'hD4
`define RPD_ADDR_STOP_KEY 8'hFB
`define RPD_ADDR_BT_COUNT 8'hFD
`define RPD_ADDR_STATUS 8'hF0
`define RPD_BT_CTRL_RST 8'h00
`define RPD_CLK_CTRL_RST 8'h80
`define RPD_CLK_CTRL_WAKE_BIT 7
`define RPD_STOP_KEY 8'hA5
`define RPD_WDT_OFF_NIB 4'hA
`define RPD_OP_STOP 8'h7F
`define RPD_OP_IDLE 8'h6F
`define RPD_RESET_VEC 16'h0100
`define RPD_CLK_MHZ 50
`define RPD_STAB_US 8
`define RPD_STAB_CYC (`RPD_STAB_US * `RPD_CLK_MHZ)
`endif

/* File: verilog/rpd_pkg.sv */
// reset and power-down controller: shared types
// assumes: nothing beyond the map header
`default_nettype none
package rpd_pkg;
  typedef enum logic [2:0] {
    RPD_RESET,
    RPD_STAB,
    RPD_RUN,
    RPD_STOP,
    RPD_IDLE
  } rpd_state_t;
endpackage
`default_nettype wire

/* File: verilog/rpd_bt_if.sv */
// link between the sequencer and its basic timer
// assumes: one clock domain
`timescale 1ns/1ps
`default_nettype none
interface rpd_bt_if;
  logic clear;
  logic wdt_en;
  logic [7:0] ctrl;
  logic [7:0] count;
  logic overflow;
  logic stab_done;
  modport seq (output clear, output wdt_en, output ctrl, input count, input overflow, input stab_done);
  modport tmr (input clear, input wdt_en, input ctrl, output count, output overflow, output stab_done);
endinterface
`default_nettype wire

/* File: verilog/rpd_basic_timer.sv */
// basic timer: watchdog counter and stabilization timer
// assumes: ctrl low bits choose the stabilization scale
`timescale 1ns/1ps
`include "rpd_map.svh"
`default_nettype none
module rpd_basic_timer (
  input wire logic core_clk,
  input wire logic rstn,
  rpd_bt_if.tmr bt
);
  logic [19:0] cnt_r;
  logic [19:0] stab_lim;
  logic [7:0] count_r;

  // stabilization length scaled by ctrl[1:0] set before stop entry
  always_comb begin
    stab_lim = 20'(`RPD_STAB_CYC) << bt.ctrl[1:0];
  end

  // free-running count; clear restarts it
  always_ff @(posedge core_clk) begin
    if (!rstn || bt.clear) begin
      cnt_r <= 20'h00000;
    end else begin
      cnt_r <= cnt_r + 20'h00001;
    end
  end

  // count readback: upper count byte, registered one cycle behind
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      count_r <= 8'h00;
    end else begin
      count_r <= cnt_r[19:12];
    end
  end

  assign bt.count = count_r;
  assign bt.overflow = bt.wdt_en && (cnt_r == 20'hFFFFF);
  assign bt.stab_done = (cnt_r >= stab_lim);
endmodule // rpd_basic_timer
`default_nettype wire

/* File: verification/rpd_ctrl_props.sv */
// checker for the reset and power-down controller top ports
// assumes: bound onto rpd_ctrl from the bench top file
`timescale 1ns/1ps
`default_nettype none
module rpd_ctrl_props (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic external_reset_pin_low,
  input wire logic low_voltage_reset,
  input wire logic opt_use_low_volt,
  input wire logic [15:0] opt_reset_vec,
  input wire logic opt_vec_sel,
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  input wire logic [7:0] filtered_ext_irqs,
  input wire logic sys_reset,
  input wire logic [15:0] pc_load_value,
  input wire logic pc_load,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic osc_run,
  input wire logic irq_global_en_clr,
  input wire logic ports_to_input,
  input wire logic hold_port_dir,
  input wire logic wake_irq,
  input wire logic [1:0] clk_div_sel
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // five samples leave room for the two sync flops
  property p_low_supply; (opt_use_low_volt && low_voltage_reset) [*5] |-> sys_reset; endproperty
  a_low_supply: assert property (p_low_supply) else $error("low supply gave no reset");
  property p_pin; (!opt_use_low_volt && !external_reset_pin_low) [*5] |-> sys_reset; endproperty
  a_pin: assert property (p_pin) else $error("pin low gave no reset");
  property p_init; sys_reset |-> irq_global_en_clr && ports_to_input && !cpu_clk_en; endproperty
  a_init: assert property (p_init) else $error("reset side effects missing");
  property p_vec; pc_load |-> pc_load_value == (opt_vec_sel ? opt_reset_vec : 16'h0100); endproperty
  a_vec: assert property (p_vec) else $error("wrong reset vector");
  property p_stab; $fell(sys_reset) |-> !cpu_clk_en [*8]; endproperty
  a_stab: assert property (p_stab) else $error("fetch before stabilization");
  property p_div; sys_reset [*2] |-> clk_div_sel == 2'b00; endproperty
  a_div: assert property (p_div) else $error("divide not cleared by reset");
  property p_stop; $fell(osc_run) |-> $past(op_valid) && $past(op_code) == 8'h7F; endproperty
  a_stop: assert property (p_stop) else $error("oscillator stopped without stop op");
  property p_frz; !osc_run |-> !cpu_clk_en && !periph_clk_en; endproperty
  a_frz: assert property (p_frz) else $error("clocks run in stop");
  property p_idle; hold_port_dir |-> !cpu_clk_en && periph_clk_en && osc_run; endproperty
  a_idle: assert property (p_idle) else $error("idle gating wrong");
  property p_wake; $rose(wake_irq) |-> !sys_reset && $past(filtered_ext_irqs, 2) != 8'h00; endproperty
  a_wake: assert property (p_wake) else $error("wake without filtered irq");
endmodule // rpd_ctrl_props
`default_nettype wire

/* File: verification/rpd_cpu_model.sv */
// far-side model: cpu core that issues power-down opcodes
// assumes: one clock, opcodes leave only while the cpu clock runs
`timescale 1ns/1ps
`default_nettype none
module rpd_cpu_model (
  input wire logic core_clk,
  input wire logic op_issue,
  input wire logic [7:0] op_req,
  input wire logic cpu_clk_en,
  output logic op_valid,
  output logic [7:0] op_code
);
  // a gated cpu decodes nothing; idle opcode lines toggle so stale values never pass
  always_ff @(posedge core_clk) begin
    op_valid <= op_issue && cpu_clk_en;
    op_code <= op_issue ? op_req : ~op_code;
  end
endmodule // rpd_cpu_model
`default_nettype wire

/* File: verification/rpd_ctrl_tb.sv */
// bench for the reset and power-down controller
// assumes: rpd_ctrl, rpd_cpu_model and rpd_ctrl_props compiled before
`timescale 1ns/1ps
`default_nettype none
module rpd_ctrl_tb;
  logic core_clk = 0, rstn = 0, external_reset_pin_low = 1, low_voltage_reset = 0, opt_use_low_volt = 0;
  logic opt_vec_sel = 0, reg_wr = 0, reg_rd = 0, irq_pending_enabled = 0, op_issue = 0;
  logic [15:0] opt_reset_vec = 16'h0000;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, op_req = 8'h00, filtered_ext_irqs = 8'h00, d;
  logic [7:0] reg_rdata, op_code;
  logic [15:0] pc_load_value;
  logic [1:0] clk_div_sel, dv, bs;
  logic op_valid, sys_reset, pc_load, cpu_clk_en, periph_clk_en, osc_run;
  logic irq_global_en_clr, ports_to_input, hold_port_dir, wake_irq;
  int fails = 0, samples_checked = 0, cyc = 0, n;
  rpd_ctrl dut (.core_clk, .rstn, .external_reset_pin_low, .low_voltage_reset, .opt_use_low_volt,
    .opt_reset_vec, .opt_vec_sel, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .op_valid,
    .op_code, .filtered_ext_irqs, .irq_pending_enabled, .sys_reset, .pc_load_value, .pc_load,
    .cpu_clk_en, .periph_clk_en, .osc_run, .irq_global_en_clr, .ports_to_input, .hold_port_dir,
    .wake_irq, .clk_div_sel);
  rpd_cpu_model cpu (.core_clk, .op_issue, .op_req, .cpu_clk_en, .op_valid, .op_code);
  always #10 core_clk = ~core_clk;
  // hang guard, run needs about 5000 cycles with the longest timer scale
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic op(input logic [7:0] c);
    @(posedge core_clk);
    op_issue <= 1'b1; op_req <= c;
    @(posedge core_clk);
    op_issue <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  // looks just after each edge so the run state is settled; a stuck wait counts as a mismatch
  task automatic wait_run();
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < 4000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 4000) fails++;
  endtask
  // expected stabilization length for a timer scale field
  function automatic int stab_cycles(input logic [1:0] s);
    return 400 << s;
  endfunction
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hF5BDC329));
    // power-on: defaults, vector, stabilization wait; converter never modelled here
    repeat (5) @(posedge core_clk);
    chk(sys_reset, 1'b1);
    rstn <= 1'b1;
    wait_run();
    chk(16'(n >= stab_cycles(2'b00) && n <= stab_cycles(2'b00) + 8), 16'h0001);
    chk(pc_load_value, 16'h0100);
    bus_rd(8'hD3, d); chk(d, 8'h00);
    bus_rd(8'hD4, d); chk(d, 8'h80);
    bus_rd(8'hFB, d); chk(d, 8'h00);
    bus_rd(8'hF0, d); chk(d, 8'h02);
    bus_rd(8'hFC, d); chk(d, 8'h00);
    $display("reset test done");
    op(8'h7F); chk(osc_run, 1'b1);
    // random divide, key then stop, woken by one filtered irq
    dv = 2'($urandom);
    bs = 2'($urandom);
    bus_wr(8'hD4, {1'b1, 2'b00, dv, 3'b000});
    // watchdog off and a random stabilization scale set before stop entry
    bus_wr(8'hD3, {4'hA, 2'b00, bs});
    bus_wr(8'hFB, 8'hA5);
    op(8'h7F); chk(osc_run, 1'b0);
    chk(periph_clk_en, 1'b0);
    irq_pending_enabled <= 1'b1;
    repeat (10) @(posedge core_clk);
    #1 chk(osc_run, 1'b0);
    irq_pending_enabled <= 1'b0;
    filtered_ext_irqs <= 8'(1 << ($urandom % 8));
    wait_run(); chk(cpu_clk_en, 1'b1);
    chk(16'(n >= stab_cycles(bs) && n <= stab_cycles(bs) + 8), 16'h0001);
    chk(wake_irq, 1'b1);
    chk(clk_div_sel, dv);
    filtered_ext_irqs <= 8'h00;
    bus_rd(8'hD3, d); chk(d, {4'hA, 2'b00, bs});
    $display("stop test done");
    op(8'h6F); chk(hold_port_dir, 1'b1);
    chk(cpu_clk_en, 1'b0);
    irq_pending_enabled <= 1'b1;
    wait_run(); chk(cpu_clk_en, 1'b1);
    chk(clk_div_sel, dv);
    irq_pending_enabled <= 1'b0;
    $display("idle test done");
    // supply reset with the alternate vector
    opt_reset_vec <= 16'($urandom); opt_vec_sel <= 1'b1; opt_use_low_volt <= 1'b1; low_voltage_reset <= 1'b1;
    repeat (20) @(posedge core_clk);
    #1 chk(sys_reset, 1'b1);
    chk(clk_div_sel, 2'b00);
    low_voltage_reset <= 1'b0;
    wait_run(); chk(pc_load_value, opt_reset_vec);
    opt_use_low_volt <= 1'b0;
    low_voltage_reset <= 1'b1;
    $display("supply reset test done");
    // pin reset ends stop mode; the supply input must be ignored while the pin is the source
    bus_wr(8'hD4, 8'h98);
    bus_wr(8'hFB, 8'hA5);
    op(8'h7F); chk(osc_run, 1'b0);
    chk(sys_reset, 1'b0);
    chk(clk_div_sel, 2'b11);
    external_reset_pin_low <= 1'b0;
    repeat (10) @(posedge core_clk);
    #1 chk(sys_reset, 1'b1);
    external_reset_pin_low <= 1'b1;
    low_voltage_reset <= 1'b0;
    wait_run(); chk(cpu_clk_en, 1'b1);
    chk(clk_div_sel, 2'b00);
    chk(wake_irq, 1'b0);
    bus_rd(8'hFB, d); chk(d, 8'h00);
    $display("pin reset test done");
    wrap_up();
  end
endmodule // rpd_ctrl_tb
bind rpd_ctrl rpd_ctrl_props chk_i (.*);
`default_nettype wire
